// ---- hdl/limit_test_binning_sequencer.sv ----
// limit test sequencer with grading/sorting binning and apb registers
`timescale 1ns/10ps
`default_nettype none
module limit_test_binning_sequencer (
   input wire logic CLOCK_I, // 20 MHz system clock
   input wire logic SRST_I, // synchronous reset, high
   input wire logic PSEL_I, // apb select
   input wire logic PENABLE_I, // apb access phase
   input wire logic PWRITE_I, // apb direction
   input wire logic [limit_seq_pkg::ADDR_W-1:0] PADDR_I, // apb byte address
   input wire logic [31:0] PWDATA_I, // apb write data
   output logic [31:0] PRDATA_O, // apb read data
   output logic PREADY_O, // apb ready
   output logic PSLVERR_O, // apb error, unmapped
   output logic MEAS_START_O, // pulse: start source-measure action
   input wire logic MEAS_DONE_I, // pulse: conversion complete
   input wire logic [limit_seq_pkg::VAL_W-1:0] MEAS_VALUE_I, // converted value
   input wire logic START_OF_TEST_STROBE_I, // handler start pulse
   output logic [limit_seq_pkg::PAT_W-1:0] BIN_PATTERN_O, // handler pattern
   output logic BIN_STROBE_O, // pulse: pattern is new
   output logic PASS_O, // pass indication
   output logic FAIL_O, // fail indication
   output logic TAG_VALID_O, // pulse: reading finished
   output logic TAG_FAIL_O, // tag of that reading
   output logic BUSY_O // testing in progress
);
   import limit_seq_pkg::*;

   state_s s_q;
   state_s s_d;
   logic acc_w;
   logic wr_w;
   logic run_w;
   logic map_w;
   logic [3:0] slot_w;
   logic [3:0] widx_w;
   logic in_win_w;
   logic compl_w;

   // apb decode; the slave never inserts wait states
   assign acc_w = PSEL_I & PENABLE_I;
   assign wr_w = acc_w & PWRITE_I;
   assign slot_w = PADDR_I[5:2];
   assign run_w = wr_w && PADDR_I == OFS_CMD && PWDATA_I[CMD_RUN];
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = acc_w & ~map_w;
   assign PRDATA_O = s_q.rdata;

   always_comb begin
      map_w = 1'b0;
      if (PADDR_I[1:0] == 2'h0) begin
         unique case (PADDR_I[7:6])
            2'h0: map_w = PADDR_I[5:0] <= OFS_FLAGS[5:0];
            PG_FPAT: map_w = slot_w < 4'(NUM_TESTS);
            default: map_w = slot_w < 4'(NUM_WIN);
         endcase
      end
   end

   // window and compliance compare on the held measurement
   assign widx_w = s_q.idx - 4'h1;
   assign in_win_w = s_q.meas <= s_q.cfg.hi[widx_w] &&
      s_q.meas >= s_q.cfg.lo[widx_w];
   // at or above is in compliance
   assign compl_w = s_q.meas >= s_q.cfg.compl;

   always_comb begin
      logic go;
      logic rd_done;
      logic rd_fail;
      logic [PAT_W-1:0] rd_pat;
      logic do_bin;
      logic [PAT_W-1:0] bpat;
      s_d = s_q;
      go = 1'b0;
      rd_done = 1'b0;
      rd_fail = 1'b0;
      rd_pat = s_q.cfg.pass_pat;
      do_bin = 1'b0;
      bpat = s_q.cfg.pass_pat;
      s_d.bin_stb = 1'b0;
      s_d.meas_start = 1'b0;
      s_d.tag_vld = 1'b0;

      // register writes
      if (wr_w) begin
         unique case (PADDR_I[7:6])
            2'h0: begin
               unique case (PADDR_I)
                  OFS_CTRL: begin
                     s_d.cfg.grade = PWDATA_I[CTRL_GRADE];
                     s_d.cfg.endbin = PWDATA_I[CTRL_ENDBIN];
                     s_d.cfg.handler = PWDATA_I[CTRL_HANDLER];
                  end
                  OFS_ENABLE: s_d.cfg.en = PWDATA_I[NUM_TESTS-1:0];
                  OFS_CYCLES: s_d.cfg.cycles = PWDATA_I[CNT_W-1:0];
                  OFS_DEVICES: s_d.cfg.devices = PWDATA_I[CNT_W-1:0];
                  OFS_COMPL: s_d.cfg.compl = PWDATA_I[VAL_W-1:0];
                  OFS_PASSPAT: s_d.cfg.pass_pat = PWDATA_I[PAT_W-1:0];
                  default: ;
               endcase
            end
            PG_HI: if (slot_w < 4'(NUM_WIN)) begin
               s_d.cfg.hi[slot_w] = PWDATA_I[VAL_W-1:0];
            end
            PG_LO: if (slot_w < 4'(NUM_WIN)) begin
               s_d.cfg.lo[slot_w] = PWDATA_I[VAL_W-1:0];
            end
            PG_FPAT: if (slot_w < 4'(NUM_TESTS)) begin
               s_d.cfg.fpat[slot_w] = PWDATA_I[PAT_W-1:0];
            end
         endcase
      end

      // read data captured in the setup cycle
      if (PSEL_I && !PENABLE_I) begin
         s_d.rdata = 32'h0;
         unique case (PADDR_I[7:6])
            2'h0: begin
               unique case (PADDR_I)
                  OFS_CTRL: s_d.rdata[2:0] = {s_q.cfg.handler,
                     s_q.cfg.endbin, s_q.cfg.grade};
                  OFS_ENABLE: s_d.rdata[NUM_TESTS-1:0] = s_q.cfg.en;
                  OFS_CYCLES: s_d.rdata[CNT_W-1:0] = s_q.cfg.cycles;
                  OFS_DEVICES: s_d.rdata[CNT_W-1:0] = s_q.cfg.devices;
                  OFS_COMPL: s_d.rdata[VAL_W-1:0] = s_q.cfg.compl;
                  OFS_PASSPAT: s_d.rdata[PAT_W-1:0] = s_q.cfg.pass_pat;
                  OFS_STATUS: s_d.rdata[7:0] = {s_q.st, 1'b0, s_q.ff_vld,
                     s_q.fail_ind, s_q.pass_ind, BUSY_O};
                  // one fail bit per test number
                  OFS_FLAGS: s_d.rdata[NUM_TESTS-1:0] = s_q.flags;
                  default: ;
               endcase
            end
            PG_HI: if (slot_w < 4'(NUM_WIN)) begin
               s_d.rdata[VAL_W-1:0] = s_q.cfg.hi[slot_w];
            end
            PG_LO: if (slot_w < 4'(NUM_WIN)) begin
               s_d.rdata[VAL_W-1:0] = s_q.cfg.lo[slot_w];
            end
            PG_FPAT: if (slot_w < 4'(NUM_TESTS)) begin
               s_d.rdata[PAT_W-1:0] = s_q.cfg.fpat[slot_w];
            end
         endcase
      end

      // sequencer
      unique case (s_q.st)
         ST_IDLE: if (run_w) begin
            s_d.dev = '0;
            // handler present: arm and wait for strobe
            if (s_q.cfg.handler) s_d.st = ST_ARMED;
            else go = 1'b1;
         end
         ST_ARMED: if (START_OF_TEST_STROBE_I || !s_q.cfg.handler) begin
            go = 1'b1;
         end
         ST_SRC: begin
            s_d.meas_start = 1'b1;
            s_d.st = ST_WAIT;
         end
         ST_WAIT: if (MEAS_DONE_I) begin
            s_d.meas = MEAS_VALUE_I;
            s_d.idx = 4'h0;
            s_d.st = ST_EVAL;
         end
         ST_EVAL: begin
            // step upward one test per clock
            s_d.idx = s_q.idx + 4'h1;
            if (!s_q.cfg.en[s_q.idx]) begin
            end else if (s_q.idx == 4'h0) begin
               if (compl_w) begin
                  s_d.flags[0] = 1'b1;
                  rd_done = 1'b1;
                  rd_fail = 1'b1;
                  rd_pat = s_q.cfg.fpat[0];
               end
            end else if (s_q.cfg.grade) begin
               if (!in_win_w) begin
                  s_d.flags[s_q.idx] = 1'b1;
                  rd_done = 1'b1;
                  rd_fail = 1'b1;
                  rd_pat = s_q.cfg.fpat[s_q.idx];
               end
            end else begin
               if (in_win_w) begin
                  rd_done = 1'b1;
               end else begin
                  s_d.flags[s_q.idx] = 1'b1;
                  if (!s_q.ff_vld) begin
                     s_d.ff_vld = 1'b1;
                     s_d.ff_pat = s_q.cfg.fpat[s_q.idx];
                  end
               end
            end
            // last of the eleven tests reached
            if (!rd_done && s_q.idx == 4'(NUM_TESTS - 1)) begin
               rd_done = 1'b1;
               if (!s_q.cfg.grade && s_d.ff_vld) begin
                  rd_fail = 1'b1;
                  rd_pat = s_d.ff_pat;
               end
            end
         end
         ST_CYC_END: begin
            if (s_q.cyc + 8'h1 < s_q.cfg.cycles) begin
               s_d.cyc = s_q.cyc + 8'h1;
               s_d.st = ST_SRC;
            end else begin
               // earliest failure of the sweep decides
               do_bin = 1'b1;
               bpat = s_q.ff_vld ? s_q.ff_pat : s_q.cfg.pass_pat;
            end
         end
      endcase

      if (rd_done) begin
         s_d.tag_vld = 1'b1;
         s_d.tag_fail = rd_fail;
         if (rd_fail) begin
            s_d.fail_ind = 1'b1;
            if (!s_q.ff_vld && s_q.cfg.grade) begin
               s_d.ff_vld = 1'b1;
               s_d.ff_pat = rd_pat;
            end
         end
         // binning control applies to grading only
         if (s_q.cfg.grade && s_q.cfg.endbin) begin
            s_d.st = ST_CYC_END;
         end else begin
            do_bin = 1'b1;
            bpat = rd_pat;
         end
      end

      if (do_bin) begin
         s_d.bin_stb = 1'b1;
         s_d.bin_pat = bpat;
         s_d.pass_ind = ~s_d.fail_ind;
         if (s_q.dev + 8'h1 < s_q.cfg.devices) begin
            s_d.dev = s_q.dev + 8'h1;
            // via armed: one clock lets this device's pass/fail and flags show
            s_d.st = ST_ARMED;
         end else begin
            s_d.st = ST_IDLE;
         end
      end

      // fresh device: results of earlier devices dropped
      if (go) begin
         s_d.flags = '0;
         s_d.ff_vld = 1'b0;
         s_d.pass_ind = 1'b0;
         s_d.fail_ind = 1'b0;
         s_d.cyc = '0;
         s_d.st = ST_SRC;
      end

      if (run_w && s_q.st != ST_IDLE) begin
         s_d.st = ST_IDLE;
      end
   end

   // single state register; config keeps its values across aborts
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.cfg.en <= ENABLE_RST;
         s_q.cfg.cycles <= CNT_RST;
         s_q.cfg.devices <= CNT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flip-flops, except BUSY_O decoded from the state
   assign MEAS_START_O = s_q.meas_start;
   assign BIN_PATTERN_O = s_q.bin_pat;
   assign BIN_STROBE_O = s_q.bin_stb;
   assign PASS_O = s_q.pass_ind;
   assign FAIL_O = s_q.fail_ind;
   assign TAG_VALID_O = s_q.tag_vld;
   assign TAG_FAIL_O = s_q.tag_fail;
   assign BUSY_O = s_q.st != ST_IDLE && s_q.st != ST_ARMED;

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SRST_I);

   chk_wait_conversion: assert property (
      s_q.st == ST_WAIT && !MEAS_DONE_I && !run_w |=> s_q.st == ST_WAIT)
      else $error("evaluation began before conversion done");
   chk_compl_fail: assert property (
      s_q.st == ST_EVAL && s_q.idx == 4'h0 && s_q.cfg.en[0] && compl_w
      |=> FAIL_O && TAG_VALID_O && TAG_FAIL_O && s_q.flags[0])
      else $error("compliance failure not reported");
   chk_skip_disabled: assert property (
      s_q.st == ST_EVAL && !s_q.cfg.en[s_q.idx] && !run_w
      && s_q.idx < 4'(NUM_TESTS - 1)
      |=> s_q.st == ST_EVAL && s_q.idx == $past(s_q.idx) + 4'h1)
      else $error("disabled test not skipped");
   chk_sort_pass: assert property (
      s_q.st == ST_EVAL && !s_q.cfg.grade && s_q.idx != 4'h0
      && s_q.cfg.en[s_q.idx] && in_win_w && !run_w
      |=> TAG_VALID_O && !TAG_FAIL_O && s_q.st != ST_EVAL)
      else $error("sorting pass did not stop testing");
   chk_grade_imm_bin: assert property (
      s_q.st == ST_EVAL && s_q.cfg.grade && !s_q.cfg.endbin
      && s_q.idx != 4'h0 && s_q.cfg.en[s_q.idx] && !in_win_w
      |=> BIN_STROBE_O && FAIL_O
      && BIN_PATTERN_O == $past(s_q.cfg.fpat[s_q.idx]))
      else $error("immediate fail pattern wrong");
   chk_run_abort: assert property (
      run_w && s_q.st != ST_IDLE |=> s_q.st == ST_IDLE)
      else $error("run command did not end testing");
   chk_endbin_loop: assert property (
      s_q.st == ST_CYC_END && s_q.cyc + 8'h1 < s_q.cfg.cycles && !run_w
      |=> s_q.st == ST_SRC && !BIN_STROBE_O ##1 MEAS_START_O)
      else $error("end binning did not continue sweep");
   chk_start_clear: assert property (
      s_q.st == ST_ARMED && START_OF_TEST_STROBE_I && !run_w
      |=> s_q.flags == '0 && !s_q.ff_vld && !FAIL_O && s_q.st == ST_SRC)
      else $error("first failure not cleared at device start");
   chk_tag_source: assert property (
      TAG_VALID_O |-> $past(s_q.st) == ST_EVAL)
      else $error("tag outside evaluation");
endmodule : limit_test_binning_sequencer
`default_nettype wire

// ---- pkg/limit_seq_pkg.sv ----
// constants, types and state record of the limit test sequencer
`default_nettype none
package limit_seq_pkg;
   localparam int NUM_TESTS = 11;
   localparam int NUM_WIN = 10;
   localparam int VAL_W = 32;
   localparam int PAT_W = 4;
   localparam int CNT_W = 8;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ENABLE = 8'h04;
   localparam logic [7:0] OFS_CYCLES = 8'h08;
   localparam logic [7:0] OFS_DEVICES = 8'h0c;
   localparam logic [7:0] OFS_CMD = 8'h10;
   localparam logic [7:0] OFS_COMPL = 8'h14;
   localparam logic [7:0] OFS_PASSPAT = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   localparam logic [7:0] OFS_FLAGS = 8'h20;
   localparam logic [1:0] PG_HI = 2'h1;
   localparam logic [1:0] PG_LO = 2'h2;
   localparam logic [1:0] PG_FPAT = 2'h3;
   // control fields
   localparam int CTRL_GRADE = 0;
   localparam int CTRL_ENDBIN = 1;
   localparam int CTRL_HANDLER = 2;
   localparam int CMD_RUN = 0;
   // reset values
   localparam logic [NUM_TESTS-1:0] ENABLE_RST = 11'h000;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h01;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ARMED, ST_SRC, ST_WAIT, ST_EVAL, ST_CYC_END
   } seq_e;
   typedef struct packed {
      logic grade;
      logic endbin;
      logic handler;
      logic [NUM_TESTS-1:0] en;
      logic [CNT_W-1:0] cycles;
      logic [CNT_W-1:0] devices;
      logic [VAL_W-1:0] compl;
      logic [PAT_W-1:0] pass_pat;
      logic [NUM_WIN-1:0][VAL_W-1:0] hi;
      logic [NUM_WIN-1:0][VAL_W-1:0] lo;
      logic [NUM_TESTS-1:0][PAT_W-1:0] fpat;
   } cfg_s;
   typedef struct packed {
      cfg_s cfg;
      seq_e st;
      logic [3:0] idx;
      logic [CNT_W-1:0] cyc;
      logic [CNT_W-1:0] dev;
      logic [VAL_W-1:0] meas;
      logic ff_vld;
      logic [PAT_W-1:0] ff_pat;
      logic [NUM_TESTS-1:0] flags;
      logic pass_ind;
      logic fail_ind;
      logic [PAT_W-1:0] bin_pat;
      logic bin_stb;
      logic meas_start;
      logic tag_vld;
      logic tag_fail;
      logic [31:0] rdata;
   } state_s;
endpackage : limit_seq_pkg
`default_nettype wire

// ---- test/handler_model.sv ----
// component handler model: start strobes out, bin strobes in
`timescale 1ns/10ps
`default_nettype none
module handler_model (
   input wire logic clk_i, // system clock
   input wire logic rst_i, // sync reset, high
   input wire logic go_i, // bench lets devices start
   input wire logic [7:0] gap_i, // wait before each strobe
   input wire logic bin_stb_i, // bin pattern is new
   output logic sot_o // start-of-test strobe
);
   logic wait_q;
   logic [7:0] cnt_q;
   // one strobe per device; no further strobe until its bin arrives or go_i drops
   // strobe pacing
   always_ff @(posedge clk_i) begin
      if (rst_i || !go_i || bin_stb_i) begin
         sot_o <= 1'b0;
         wait_q <= 1'b0;
         cnt_q <= 8'h00;
      end else if (!wait_q && cnt_q == gap_i) begin
         sot_o <= 1'b1;
         wait_q <= 1'b1;
      end else begin
         sot_o <= 1'b0;
         if (!wait_q) begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end
endmodule : handler_model
`default_nettype wire

// ---- test/limit_test_binning_sequencer_test.sv ----
// self-checking bench of the limit test sequencer
`timescale 1ns/10ps
`default_nettype none
module limit_test_binning_sequencer_test;
   import limit_seq_pkg::*;
   logic clk, srst, psel, penable, pwrite, pready, pslverr, err_q;
   logic meas_start, meas_done, start_of_test_strobe, hgo, meas_hold, bin_stb, pass, fail;
   logic tag_vld, tag_fail, busy;
   logic [7:0] paddr, hgap;
   logic [31:0] pwdata, prdata, meas_val, rd_q;
   logic [3:0] bin_pat;
   logic [2:0] dly;
   int err_total, tests_run, nbin, ntag, nfail, nmeas, cycles, tmark;
   logic [31:0] vals[$];
   logic [31:0] exp_pats[$];

   limit_test_binning_sequencer u_dut (
      .CLOCK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .MEAS_START_O(meas_start),
      .MEAS_DONE_I(meas_done), .MEAS_VALUE_I(meas_val), .START_OF_TEST_STROBE_I(start_of_test_strobe),
      .BIN_PATTERN_O(bin_pat), .BIN_STROBE_O(bin_stb), .PASS_O(pass), .FAIL_O(fail),
      .TAG_VALID_O(tag_vld), .TAG_FAIL_O(tag_fail), .BUSY_O(busy));
   handler_model u_handler (
      .clk_i(clk), .rst_i(srst), .go_i(hgo), .gap_i(hgap), .bin_stb_i(bin_stb),
      .sot_o(start_of_test_strobe));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // apb transfer; holds the request until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // a hang anywhere counts as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         end_of_test();
      end
   end

   // conversion answers three cycles after a start; the value toggles otherwise
   always @(posedge clk) begin
      if (meas_start === 1'b1 && !meas_hold) begin
         dly <= 3'h3;
      end else if (dly != 3'h0) begin
         dly <= dly - 3'h1;
      end
      if (dly == 3'h1 && vals.size() > 0) begin
         meas_done <= 1'b1;
         meas_val <= vals.pop_front();
      end else begin
         meas_done <= 1'b0;
         meas_val <= ~meas_val;
      end
   end

   // counts pulses and checks each bin pattern as it appears
   always @(posedge clk) begin
      if (!srst && bin_stb === 1'b1) begin
         nbin++;
         if (exp_pats.size() > 0) begin
            chk({28'h0, bin_pat}, exp_pats.pop_front());
         end
      end
      if (!srst && tag_vld === 1'b1) ntag++;
      if (!srst && tag_vld === 1'b1 && tag_fail === 1'b1) nfail++;
      if (!srst && meas_start === 1'b1) nmeas++;
   end

   // one limit run over dev devices; values and patterns queued by caller
   task automatic do_run(input logic [2:0] ctrl, input logic [10:0] en,
                         input logic [7:0] cyc, input logic [7:0] dev, input logic [7:0] gap,
                         input logic [31:0] flg, input logic ok, input int nf);
      int b0, t0, f0, m0;
      b0 = nbin;
      t0 = ntag;
      f0 = nfail;
      m0 = nmeas;
      hgap <= gap;
      apb(1'b1, OFS_CTRL, {29'h0, ctrl});
      apb(1'b1, OFS_ENABLE, {21'h0, en});
      apb(1'b1, OFS_CYCLES, {24'h0, cyc});
      apb(1'b1, OFS_DEVICES, {24'h0, dev});
      apb(1'b1, OFS_CMD, 32'h1);
      hgo <= ctrl[2];
      while (nbin - b0 < int'(dev)) @(posedge clk);
      hgo <= 1'b0;
      repeat (4) @(posedge clk);
      chk({31'h0, busy}, 32'h0);
      chk(32'(nbin - b0), 32'(dev));
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd_q & 32'he0, 32'h0);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(rd_q, flg);
      chk({30'h0, pass, fail}, {30'h0, ok, !ok});
      chk(32'(ntag - t0), 32'(dev * cyc));
      chk(32'(nfail - f0), 32'(nf));
      chk(32'(nmeas - m0), 32'(dev * cyc));
      $display("test done ctrl %h enables %h", ctrl, en);
   endtask : do_run

   initial begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      meas_done = 1'b0;
      meas_val = 32'h0;
      dly = 3'h0;
      hgo = 1'b0;
      hgap = 8'h02;
      meas_hold = 1'b0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      // reset values, field width and an unmapped place
      apb(1'b0, OFS_ENABLE, 32'h0);
      chk(rd_q, 32'h0);
      apb(1'b0, OFS_CYCLES, 32'h0);
      chk(rd_q, 32'h1);
      apb(1'b0, OFS_DEVICES, 32'h0);
      chk(rd_q, 32'h1);
      apb(1'b1, OFS_ENABLE, 32'hffffffff);
      apb(1'b0, OFS_ENABLE, 32'h0);
      chk(rd_q, 32'h7ff);
      apb(1'b0, 8'h24, 32'h0);
      chk({err_q, rd_q[30:0]}, 32'h80000000);
      $display("test done registers");
      // limits: window 0 100..200, window 1 140..160, others 300..400
      apb(1'b1, OFS_COMPL, 32'd1000);
      apb(1'b1, OFS_PASSPAT, 32'hf);
      for (int i = 0; i < 11; i++) begin
         apb(1'b1, 8'hc0 + 8'(4 * i), 32'(i + 1));
         if (i < 10) begin
            apb(1'b1, 8'h40 + 8'(4 * i), 32'((i == 0) ? 200 : (i == 1) ? 160 : 400));
            apb(1'b1, 8'h80 + 8'(4 * i), 32'((i == 0) ? 100 : (i == 1) ? 140 : 300));
         end
      end
      // grading, immediate: pass, fine fail, compliance at limit, coarse fail
      vals = '{32'd160, 32'd120, 32'd1000, 32'd999};
      exp_pats = '{32'hf, 32'h3, 32'h1, 32'h2};
      do_run(3'h5, 11'h007, 8'd1, 8'd4, 8'd2, 32'h002, 1'b0, 3);
      // grading, end binning: earliest failure of the sweep wins
      vals = '{32'd150, 32'd120, 32'd300, 32'd150, 32'd150, 32'd150};
      exp_pats = '{32'h3, 32'hf};
      do_run(3'h7, 11'h007, 8'd3, 8'd2, 8'd7, 32'h0, 1'b1, 2);
      // sorting, no handler: first pass wins, compliance fail, all fail
      vals = '{32'd150, 32'd350, 32'd1200, 32'd500};
      exp_pats = '{32'hf, 32'hf, 32'h1, 32'h2};
      do_run(3'h0, 11'h403, 8'd1, 8'd4, 8'd2, 32'h402, 1'b0, 2);
      // grading with middle tests disabled: only the last window runs
      vals = '{32'd350, 32'd150};
      exp_pats = '{32'hf, 32'hb};
      do_run(3'h5, 11'h401, 8'd1, 8'd2, 8'd3, 32'h400, 1'b0, 1);
      // second run command while waiting on a conversion aborts
      meas_hold <= 1'b1;
      apb(1'b1, OFS_CTRL, 32'h1);
      tmark = ntag;
      apb(1'b1, OFS_CMD, 32'h1);
      while (busy !== 1'b1) @(posedge clk);
      repeat (3) @(posedge clk);
      apb(1'b1, OFS_CMD, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, busy}, 32'h0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd_q & 32'he0, 32'h0);
      chk(32'(ntag - tmark), 32'h0);
      meas_hold <= 1'b0;
      $display("test done abort");
      end_of_test();
   end
endmodule : limit_test_binning_sequencer_test
`default_nettype wire
